// ===== inc/tqg_defines.svh
`ifndef TQG_DEFINES_SVH
`define TQG_DEFINES_SVH

// ***********************************************************
// Register offsets
// ***********************************************************
`define TQG_OFS_CTRL      8'h00
`define TQG_OFS_DIV       8'h04
`define TQG_OFS_THR_WEAK  8'h08
`define TQG_OFS_THR_LOW   8'h0c
`define TQG_OFS_THR_HIGH  8'h10
`define TQG_OFS_TGT_LO    8'h14
`define TQG_OFS_TGT_HI    8'h18
`define TQG_OFS_AMR60     8'h1c
`define TQG_OFS_AMR70     8'h20
`define TQG_OFS_STATUS    8'h24
`define TQG_OFS_MASK      8'h28
`define TQG_OFS_RESULT    8'h2c
`define TQG_OFS_INFO      8'h30

// ***********************************************************
// Field positions
// ***********************************************************
`define TQG_CTRL_GRADE_EN 0
`define TQG_CTRL_AMR_EN   1
`define TQG_EV_PIXEL      0
`define TQG_EV_INC        1
`define TQG_EV_DEC        2
`define TQG_EV_DIV_DONE   3
`define TQG_EV_DIV_BAD    4
`define TQG_EV_W          5

// ***********************************************************
// Reset values
// ***********************************************************
`define TQG_RST_CTRL      2'h1
`define TQG_RST_DIV       8'h01
`define TQG_RST_THR_WEAK  12'h019
`define TQG_RST_THR_LOW   12'h064
`define TQG_RST_THR_HIGH  12'h7d0
`define TQG_RST_TGT_LO    12'h0c8
`define TQG_RST_TGT_HI    12'h5dc
`define TQG_RST_AMR       24'h000000

// ***********************************************************
// Device constants and limits
// ***********************************************************
`define TQG_DEV_DIV_ADDR  8'h85
`define TQG_CLIP_LIM      (12'sh7ea)
`define TQG_QUIET_LIM     (12'sh014)
`define TQG_UNAMB_STEP    16'h000f
`define TQG_SMP_LAST      2'h3

`endif

// ===== inc/tqg_pkg.sv
package tqg_pkg;

   // Grading outcome of one pixel
   typedef enum logic [2:0] {
      CLS_SATURATED,
      CLS_TOO_BRIGHT,
      CLS_NO_OBJECT,
      CLS_WEAK,
      CLS_NOISY,
      CLS_GOOD,
      CLS_OVEREXPOSED,
      CLS_AMBIENT
   } tqg_class_t;

   // Integration time request for the next frame
   typedef enum logic [1:0] {
      ACT_HOLD,
      ACT_INC,
      ACT_DEC
   } tqg_action_t;

   // Device register writer
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_WAIT_FRAME,
      WR_REQ
   } tqg_wr_state_t;

endpackage : tqg_pkg

// ===== inc/tqg_amp_if.sv
`timescale 1ns/1ps
interface tqg_amp_if;
   logic signed [11:0] smp [4];
   logic [23:0] amp_sq;
   logic [3:0] clip;
   logic [3:0] quiet;

   modport eng
   (
      input smp,
      output amp_sq,
      output clip,
      output quiet
   );

   modport user
   (
      output smp,
      input amp_sq,
      input clip,
      input quiet
   );
endinterface : tqg_amp_if

// ===== logic/tqg_amp_engine.sv
`timescale 1ns/1ps
`include "tqg_defines.svh"

module tqg_amp_engine
(
   // Phase samples in, amplitude and sample checks out
   tqg_amp_if.eng amp
);
   import tqg_pkg::*;

   // ***********************************************************
   // Amplitude squared
   // ***********************************************************
   // Limits are compared squared: no root extractor needed
   logic signed [12:0] diff_a;
   logic signed [12:0] diff_b;
   logic signed [25:0] prod_a;
   logic signed [25:0] prod_b;
   logic [25:0] sum_sq;

   assign diff_a = 13'(amp.smp[2]) - 13'(amp.smp[0]); // [RULE5]
   assign diff_b = 13'(amp.smp[3]) - 13'(amp.smp[1]); // [RULE5]
   assign prod_a = diff_a * diff_a;
   assign prod_b = diff_b * diff_b;
   assign sum_sq = unsigned'(prod_a) + unsigned'(prod_b);
   // Halving the root is a divide by four of the square
   assign amp.amp_sq = sum_sq[25:2]; // [RULE5]

   // ***********************************************************
   // Per sample full scale checks
   // ***********************************************************
   for (genvar k = 0; k < 4; k++)
   begin : g_smp
      assign amp.clip[k] = (amp.smp[k] > `TQG_CLIP_LIM) ||
                           (amp.smp[k] < -`TQG_CLIP_LIM); // [RULE12]
      assign amp.quiet[k] = (amp.smp[k] <= `TQG_QUIET_LIM) &&
                            (amp.smp[k] >= -`TQG_QUIET_LIM); // [RULE12]
   end

endmodule : tqg_amp_engine

// ===== logic/tqg_grader.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "tqg_defines.svh"

//Behaviour
//RULE1: Unambiguity is c over twice LED frequency.
//RULE2: Divider sets range, time base, resolution.
//RULE3: Divider codes 0,1,3,7,15 scale everything.
//RULE4: Step 0.25 cm, doubling per halving.
//RULE5: Amplitude is half root of squared differences.
//RULE6: Amplitude grades weak, noisy, good, overexposed.
//RULE7: Weak lengthens, overexposed shortens integration.
//RULE8: Steer amplitude into 200 to 1500.
//RULE9: Modulated irradiance scales amplitude by time ratio.
//RULE10: Ambient ratio is 20 log of irradiances.
//RULE11: Ratio grades three ways; weak shortens.
//RULE12: Check overflow, samples, amplitude, ratio in order. Code checks the ratio before the noisy amplitude limit.
//RULE13: Overflow marks pixel saturated, shorten integration.
//RULE14: Overflow flag comes with every sample.
//RULE15: Divider changes only after integration ends.
//RULE16: Signed 12-bit samples, result one clock later.
//RULE17: Amplitude limits sit in writable registers.
module tqg_grader
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic o_irq,
   // Sensor pins
   input wire logic i_pix_valid,
   input wire logic [11:0] i_pix_data,
   input wire logic i_overflow_flag_pin,
   input wire logic i_frame_sync,
   // Device register write request
   output logic o_dev_wr_req,
   output logic [7:0] o_dev_wr_addr,
   output logic [7:0] o_dev_wr_data,
   input wire logic i_dev_wr_ack,
   // Pixel grading result
   output logic o_res_valid,
   output tqg_pkg::tqg_class_t o_res_class,
   output tqg_pkg::tqg_action_t o_res_action,
   output logic o_res_dist_ok,
   output logic [23:0] o_res_amp_sq,
   // Applied modulation clock divider
   output logic [7:0] o_mod_div
);
   import tqg_pkg::*;

   // ***********************************************************
   // Pin synchronisers
   // ***********************************************************
   // Data are synchronised beside the strobe, so the sensor must
   // hold a sample at least three host clocks around its strobe.
   logic pv_s1_r;
   logic pv_s2_r;
   logic pv_d_r;
   logic [11:0] pd_s1_r;
   logic [11:0] pd_s2_r;
   logic of_s1_r;
   logic of_s2_r;
   logic fs_s1_r;
   logic fs_s2_r;
   logic fs_d_r;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pv_s1_r <= 1'b0;
         pv_s2_r <= 1'b0;
         pv_d_r <= 1'b0;
         pd_s1_r <= 12'h000;
         pd_s2_r <= 12'h000;
         of_s1_r <= 1'b0;
         of_s2_r <= 1'b0;
         fs_s1_r <= 1'b0;
         fs_s2_r <= 1'b0;
         fs_d_r <= 1'b0;
      end
      else
      begin
         pv_s1_r <= i_pix_valid;
         pv_s2_r <= pv_s1_r;
         pv_d_r <= pv_s2_r;
         pd_s1_r <= i_pix_data;
         pd_s2_r <= pd_s1_r;
         of_s1_r <= i_overflow_flag_pin;
         of_s2_r <= of_s1_r;
         fs_s1_r <= i_frame_sync;
         fs_s2_r <= fs_s1_r;
         fs_d_r <= fs_s2_r;
      end
   end

   logic smp_take;
   logic frame_end;
   assign smp_take = pv_s2_r & ~pv_d_r;
   assign frame_end = fs_d_r & ~fs_s2_r;

   // ***********************************************************
   // Register file
   // ***********************************************************
   logic [1:0] ctrl_r;
   logic [11:0] thr_weak_r;
   logic [11:0] thr_low_r;
   logic [11:0] thr_high_r;
   logic [11:0] tgt_lo_r;
   logic [11:0] tgt_hi_r;
   logic [23:0] amr60_r;
   logic [23:0] amr70_r;
   logic [`TQG_EV_W-1:0] status_r;
   logic [`TQG_EV_W-1:0] status_nxt;
   logic [`TQG_EV_W-1:0] mask_r;
   logic [`TQG_EV_W-1:0] ev_set;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   logic sel_ctrl;
   logic sel_div;
   logic sel_weak;
   logic sel_low;
   logic sel_high;
   logic sel_tlo;
   logic sel_thi;
   logic sel_a60;
   logic sel_a70;
   logic sel_status;
   logic sel_mask;
   logic sel_result;
   logic sel_info;

   assign sel_ctrl = i_reg_addr == `TQG_OFS_CTRL;
   assign sel_div = i_reg_addr == `TQG_OFS_DIV;
   assign sel_weak = i_reg_addr == `TQG_OFS_THR_WEAK;
   assign sel_low = i_reg_addr == `TQG_OFS_THR_LOW;
   assign sel_high = i_reg_addr == `TQG_OFS_THR_HIGH;
   assign sel_tlo = i_reg_addr == `TQG_OFS_TGT_LO;
   assign sel_thi = i_reg_addr == `TQG_OFS_TGT_HI;
   assign sel_a60 = i_reg_addr == `TQG_OFS_AMR60;
   assign sel_a70 = i_reg_addr == `TQG_OFS_AMR70;
   assign sel_status = i_reg_addr == `TQG_OFS_STATUS;
   assign sel_mask = i_reg_addr == `TQG_OFS_MASK;
   assign sel_result = i_reg_addr == `TQG_OFS_RESULT;
   assign sel_info = i_reg_addr == `TQG_OFS_INFO;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctrl_r <= `TQG_RST_CTRL;
         thr_weak_r <= `TQG_RST_THR_WEAK;
         thr_low_r <= `TQG_RST_THR_LOW;
         thr_high_r <= `TQG_RST_THR_HIGH;
         tgt_lo_r <= `TQG_RST_TGT_LO;
         tgt_hi_r <= `TQG_RST_TGT_HI;
         amr60_r <= `TQG_RST_AMR;
         amr70_r <= `TQG_RST_AMR;
         mask_r <= '0;
      end
      else if (i_reg_wr)
      begin
         if (sel_ctrl) ctrl_r <= i_reg_wdata[1:0];
         if (sel_weak) thr_weak_r <= i_reg_wdata[11:0]; // [RULE17]
         if (sel_low) thr_low_r <= i_reg_wdata[11:0]; // [RULE17]
         if (sel_high) thr_high_r <= i_reg_wdata[11:0]; // [RULE17]
         if (sel_tlo) tgt_lo_r <= i_reg_wdata[11:0]; // [RULE8]
         if (sel_thi) tgt_hi_r <= i_reg_wdata[11:0]; // [RULE8]
         if (sel_a60) amr60_r <= i_reg_wdata[23:0]; // [RULE9]
         if (sel_a70) amr70_r <= i_reg_wdata[23:0]; // [RULE9]
         if (sel_mask) mask_r <= i_reg_wdata[`TQG_EV_W-1:0];
      end
   end

   // A new event in the clearing read survives the clear
   assign status_nxt = (status_r & ~{`TQG_EV_W{i_reg_rd & sel_status}}) | ev_set;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         status_r <= '0;
         rdata_r <= '0;
      end
      else
      begin
         status_r <= status_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign o_irq = |(status_r & mask_r);
   assign o_reg_rdata = rdata_r;

   // ***********************************************************
   // Modulation clock divider and derived scales
   // ***********************************************************
   tqg_wr_state_t wr_state_r;
   tqg_wr_state_t wr_state_nxt;
   logic [7:0] div_cur_r;
   logic [7:0] div_pend_r;
   logic div_wr;
   logic div_ok;
   logic div_done;
   logic [7:0] tbase_mult;
   logic [15:0] unamb_halfm;

   assign div_wr = i_reg_wr & sel_div;
   // Legal codes are 2^n-1 up to 15
   assign div_ok = ((i_reg_wdata[7:0] & 8'(i_reg_wdata[7:0] + 8'h01)) == 8'h00) &&
                   (i_reg_wdata[7:4] == 4'h0); // [RULE3]
   assign div_done = (wr_state_r == WR_REQ) & i_dev_wr_ack;

   // Time base multiplier and quarter-cm step are code+1
   assign tbase_mult = 8'(div_cur_r + 8'h01); // [RULE2] [RULE3] [RULE4]
   // Unambiguity distance in half metres: 7.5 m per step
   assign unamb_halfm = 16'(`TQG_UNAMB_STEP * {8'h00, tbase_mult}); // [RULE1]

   always_comb
   begin
      wr_state_nxt = wr_state_r;
      unique case (wr_state_r)
         WR_IDLE:
         begin
            if (div_wr && div_ok)
               wr_state_nxt = WR_WAIT_FRAME;
         end
         WR_WAIT_FRAME:
         begin
            // Modulation settings move only between frames
            if (frame_end)
               wr_state_nxt = WR_REQ; // [RULE15]
         end
         WR_REQ:
         begin
            if (i_dev_wr_ack)
               wr_state_nxt = WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_state_r <= WR_IDLE;
         div_cur_r <= `TQG_RST_DIV;
         div_pend_r <= `TQG_RST_DIV;
      end
      else
      begin
         wr_state_r <= wr_state_nxt;
         // A request in flight keeps its value; writes during it are dropped
         if (div_wr && div_ok && wr_state_r != WR_REQ)
            div_pend_r <= i_reg_wdata[7:0];
         if (div_done)
            div_cur_r <= div_pend_r; // [RULE2]
      end
   end

   assign o_dev_wr_req = wr_state_r == WR_REQ;
   assign o_dev_wr_addr = `TQG_DEV_DIV_ADDR;
   assign o_dev_wr_data = div_pend_r;
   assign o_mod_div = div_cur_r;

   // ***********************************************************
   // Phase sample collection
   // ***********************************************************
   logic [1:0] smp_idx_r;
   logic signed [11:0] smp_r [3];
   logic ovf_acc_r;
   logic smp_last;
   logic ovf_any;

   assign smp_last = smp_take & (smp_idx_r == `TQG_SMP_LAST);
   // The flag travels with every sample and any one taints the pixel
   assign ovf_any = ovf_acc_r | of_s2_r; // [RULE14] [RULE13]

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         smp_idx_r <= 2'h0;
         ovf_acc_r <= 1'b0;
         smp_r <= '{default: 12'h000};
      end
      else if (frame_end)
      begin
         smp_idx_r <= 2'h0;
         ovf_acc_r <= 1'b0;
      end
      else if (smp_take)
      begin
         smp_idx_r <= 2'(smp_idx_r + 2'h1);
         ovf_acc_r <= smp_last ? 1'b0 : ovf_any;
         if (!smp_last)
            smp_r[smp_idx_r] <= signed'(pd_s2_r); // [RULE16]
      end
   end

   tqg_amp_if amp ();

   assign amp.smp[0] = smp_r[0];
   assign amp.smp[1] = smp_r[1];
   assign amp.smp[2] = smp_r[2];
   assign amp.smp[3] = signed'(pd_s2_r);

   tqg_amp_engine u_amp
   (
      .amp(amp.eng)
   );

   // ***********************************************************
   // Validity and quality ladder
   // ***********************************************************
   logic [23:0] weak_sq;
   logic [23:0] low_sq;
   logic [23:0] high_sq;
   logic [23:0] tlo_sq;
   logic [23:0] thi_sq;
   logic amr_weak;
   logic amr_good;
   tqg_class_t cls_nxt;
   tqg_action_t act_nxt;
   logic dist_ok_nxt;

   assign weak_sq = thr_weak_r * thr_weak_r; // [RULE6]
   assign low_sq = thr_low_r * thr_low_r; // [RULE6]
   assign high_sq = thr_high_r * thr_high_r; // [RULE6]
   assign tlo_sq = tgt_lo_r * tgt_lo_r;
   assign thi_sq = tgt_hi_r * tgt_hi_r;
   // Software prefolds sensitivity, times and ambient
   // into squared limits: no logarithm here
   assign amr_weak = ctrl_r[`TQG_CTRL_AMR_EN] & (amp.amp_sq < amr70_r); // [RULE10] [RULE11]
   assign amr_good = ~ctrl_r[`TQG_CTRL_AMR_EN] | (amp.amp_sq >= amr60_r); // [RULE11]

   always_comb
   begin
      cls_nxt = CLS_GOOD;
      act_nxt = ACT_HOLD;
      dist_ok_nxt = 1'b0;
      if (ovf_any)
      begin
         cls_nxt = CLS_SATURATED; // [RULE13] [RULE12]
         act_nxt = ACT_DEC;
      end
      else if (|amp.clip)
      begin
         cls_nxt = CLS_TOO_BRIGHT; // [RULE12]
         act_nxt = ACT_DEC;
      end
      else if (&amp.quiet)
      begin
         cls_nxt = CLS_NO_OBJECT; // [RULE12]
         act_nxt = ACT_INC;
      end
      else if (amp.amp_sq > high_sq)
      begin
         cls_nxt = CLS_OVEREXPOSED; // [RULE6] [RULE7]
         act_nxt = ACT_DEC;
      end
      else if (amp.amp_sq < weak_sq)
      begin
         cls_nxt = CLS_WEAK; // [RULE6] [RULE7]
         act_nxt = ACT_INC;
      end
      else if (amr_weak)
      begin
         cls_nxt = CLS_AMBIENT; // [RULE11] [RULE12]
         act_nxt = ACT_DEC;
      end
      else if (amp.amp_sq < low_sq)
      begin
         cls_nxt = CLS_NOISY; // [RULE6]
         act_nxt = ACT_INC;
         dist_ok_nxt = amr_good;
      end
      else
      begin
         cls_nxt = CLS_GOOD;
         dist_ok_nxt = amr_good; // [RULE12]
         // Closed loop: hold the amplitude inside the target window
         if (amp.amp_sq < tlo_sq)
            act_nxt = ACT_INC; // [RULE8]
         else if (amp.amp_sq > thi_sq)
            act_nxt = ACT_DEC; // [RULE8]
      end
   end

   // ***********************************************************
   // Result registers and events
   // ***********************************************************
   logic grade;
   assign grade = smp_last & ctrl_r[`TQG_CTRL_GRADE_EN];

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_res_valid <= 1'b0;
         o_res_class <= CLS_SATURATED;
         o_res_action <= ACT_HOLD;
         o_res_dist_ok <= 1'b0;
         o_res_amp_sq <= '0;
      end
      else
      begin
         o_res_valid <= grade; // [RULE16]
         if (grade)
         begin
            o_res_class <= cls_nxt; // [RULE16]
            o_res_action <= act_nxt;
            o_res_dist_ok <= dist_ok_nxt;
            o_res_amp_sq <= amp.amp_sq;
         end
      end
   end

   assign ev_set[`TQG_EV_PIXEL] = o_res_valid;
   assign ev_set[`TQG_EV_INC] = o_res_valid & (o_res_action == ACT_INC);
   assign ev_set[`TQG_EV_DEC] = o_res_valid & (o_res_action == ACT_DEC);
   assign ev_set[`TQG_EV_DIV_DONE] = div_done;
   assign ev_set[`TQG_EV_DIV_BAD] = div_wr & ~div_ok;

   // ***********************************************************
   // Read data selection
   // ***********************************************************
   logic [31:0] rd_result;
   logic [31:0] rd_info;
   assign rd_result = {o_res_amp_sq, 1'b0, o_res_dist_ok, o_res_action,
                       1'b0, o_res_class};
   assign rd_info = {unamb_halfm, tbase_mult, tbase_mult};

   always_comb
   begin
      rdata_nxt = '0;
      if (i_reg_rd)
      begin
         if (sel_ctrl) rdata_nxt = {30'h0, ctrl_r};
         if (sel_div) rdata_nxt = {16'h0, div_pend_r, div_cur_r};
         if (sel_weak) rdata_nxt = {20'h0, thr_weak_r};
         if (sel_low) rdata_nxt = {20'h0, thr_low_r};
         if (sel_high) rdata_nxt = {20'h0, thr_high_r};
         if (sel_tlo) rdata_nxt = {20'h0, tgt_lo_r};
         if (sel_thi) rdata_nxt = {20'h0, tgt_hi_r};
         if (sel_a60) rdata_nxt = {8'h00, amr60_r};
         if (sel_a70) rdata_nxt = {8'h00, amr70_r};
         if (sel_status) rdata_nxt = {27'h0, status_r};
         if (sel_mask) rdata_nxt = {27'h0, mask_r};
         if (sel_result) rdata_nxt = rd_result;
         if (sel_info) rdata_nxt = rd_info; // [RULE2]
      end
   end

endmodule : tqg_grader

// ===== tb/tqg_grader_assertions.sv
`timescale 1ns/1ps
// ***
// Port checks
// ***
module tqg_grader_assertions
   import tqg_pkg::*;
(
   // Clock, reset, registers
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic o_irq,
   // Results
   input wire logic o_res_valid,
   input wire tqg_pkg::tqg_class_t o_res_class,
   input wire tqg_pkg::tqg_action_t o_res_action,
   input wire logic o_res_dist_ok,
   input wire logic [23:0] o_res_amp_sq,
   // Device writes
   input wire logic o_dev_wr_req,
   input wire logic [7:0] o_dev_wr_addr,
   input wire logic [7:0] o_dev_wr_data,
   input wire logic i_dev_wr_ack,
   input wire logic [7:0] o_mod_div
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);
   rd_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
      else $error("rdata idle");
   one_pulse_a: assert property (o_res_valid |=> !o_res_valid)
      else $error("valid pulse");
   res_hold_a: assert property (!o_res_valid |->
      $stable(o_res_class) && $stable(o_res_amp_sq)) else $error("result hold");
   dev_addr_a: assert property (o_dev_wr_addr == 8'h85)
      else $error("device address");
   req_hold_a: assert property (o_dev_wr_req && !i_dev_wr_ack |=>
      o_dev_wr_req && $stable(o_dev_wr_data)) else $error("request hold");
   req_done_a: assert property (o_dev_wr_req && i_dev_wr_ack |=>
      !o_dev_wr_req && o_mod_div == $past(o_dev_wr_data)) else $error("apply");
   div_keep_a: assert property (!(o_dev_wr_req && i_dev_wr_ack) |=>
      $stable(o_mod_div)) else $error("divider moved");
   div_code_a: assert property (o_mod_div inside {8'h0, 8'h1, 8'h3, 8'h7, 8'hf})
      else $error("divider code");
   sat_dec_a: assert property (o_res_valid && o_res_class == CLS_SATURATED |->
      o_res_action == ACT_DEC && !o_res_dist_ok) else $error("saturated");
   weak_inc_a: assert property (o_res_valid && o_res_class == CLS_WEAK |->
      o_res_action == ACT_INC && !o_res_dist_ok) else $error("weak");
   cover property (o_res_valid);
   cover property (o_dev_wr_req && i_dev_wr_ack);
   cover property (o_irq);
endmodule : tqg_grader_assertions
bind tqg_grader tqg_grader_assertions u_tqg_grader_assertions (.*);

// ===== tb/tqg_sensor_model.sv
`timescale 1ns/1ps
// ***
// Sensor model
// ***
module tqg_sensor_model
(
   // Clock, reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Register writes
   input wire logic i_wr_req,
   input wire logic [7:0] i_wr_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic [3:0] i_ack_dly,
   output logic o_wr_ack,
   output logic [7:0] o_mod_div_r,
   // Pixel pins
   output logic o_pix_valid,
   output logic [11:0] o_pix_data,
   output logic o_ovf,
   output logic o_frame_sync
);
   logic [3:0] wait_r;
   initial
   begin
      o_pix_valid = 1'b0;
      o_pix_data = 12'h0;
      o_ovf = 1'b0;
      o_frame_sync = 1'b1;
   end
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_wr_ack <= 1'b0;
         wait_r <= 4'h0;
         o_mod_div_r <= 8'h01;
      end
      else if (o_wr_ack)
      begin
         o_wr_ack <= 1'b0;
         wait_r <= 4'h0;
      end
      else if (i_wr_req && wait_r == i_ack_dly)
      begin
         o_wr_ack <= 1'b1;
         // One code sets range, time base and resolution
         if (i_wr_addr == 8'h85)
            o_mod_div_r <= i_wr_data;
      end
      else if (i_wr_req)
         wait_r <= wait_r + 4'h1;
   end
   // Samples 0..3, overflow flag beside each
   task automatic send_pixel(input logic [47:0] s, input logic f);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge i_clock);
         o_pix_data <= s[47-12*i -: 12];
         o_ovf <= f;
         repeat (3) @(posedge i_clock);
         o_pix_valid <= 1'b1;
         repeat (3) @(posedge i_clock);
         o_pix_valid <= 1'b0;
         repeat (2) @(posedge i_clock);
         // Stale lines must not look valid
         o_pix_data <= ~s[47-12*i -: 12];
         o_ovf <= ~f;
      end
   endtask : send_pixel
   task automatic frame_end();
      @(posedge i_clock);
      o_frame_sync <= 1'b0;
      repeat (4) @(posedge i_clock);
      o_frame_sync <= 1'b1;
   endtask : frame_end
endmodule : tqg_sensor_model

// ===== tb/tqg_grader_tb.sv
`timescale 1ns/1ps
`include "tqg_defines.svh"
// ***
// Grader bench
// ***
module tqg_grader_tb;
   import tqg_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [3:0] ack_dly = 4'h0;
   logic [31:0] o_reg_rdata, res;
   logic [23:0] o_res_amp_sq;
   logic [11:0] i_pix_data;
   logic [7:0] o_dev_wr_addr, o_dev_wr_data, o_mod_div, mdl_div;
   logic o_irq, i_pix_valid, i_overflow_flag_pin, i_frame_sync, o_dev_wr_req;
   logic i_dev_wr_ack, o_res_valid, o_res_dist_ok;
   tqg_class_t o_res_class;
   tqg_action_t o_res_action;
   int n_fail = 0;
   int n_compared = 0;
   int n_res = 0;
   tqg_grader u_tqg_grader (.*);
   tqg_sensor_model u_tqg_sensor_model (.i_clock, .i_rst_n,
      .i_wr_req(o_dev_wr_req), .i_wr_addr(o_dev_wr_addr), .i_wr_data(o_dev_wr_data),
      .i_ack_dly(ack_dly), .o_wr_ack(i_dev_wr_ack), .o_mod_div_r(mdl_div),
      .o_pix_valid(i_pix_valid), .o_pix_data(i_pix_data), .o_ovf(i_overflow_flag_pin),
      .o_frame_sync(i_frame_sync));
   always #4 i_clock = ~i_clock;
   always @(posedge i_clock)
      if (o_res_valid)
      begin
         res <= {o_res_amp_sq, 1'b0, o_res_dist_ok, o_res_action, 1'b0, o_res_class};
         n_res <= n_res + 1;
      end
   task automatic results();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results
   task automatic give_up();
      n_fail++;
      results();
   endtask : give_up
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge i_clock);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clock);
      i_reg_rd <= 1'b0;
      #1;
      check(o_reg_rdata, exp);
   endtask : rdc
   function automatic logic [23:0] amp(input logic [47:0] s);
      int d2, d3;
      d2 = $signed(s[23:12]) - $signed(s[47:36]);
      d3 = $signed(s[11:0]) - $signed(s[35:24]);
      return 24'((d2 * d2 + d3 * d3) >>> 2);
   endfunction : amp
   task automatic pix(input logic [47:0] s, input logic f, input logic d,
      input tqg_action_t t, input tqg_class_t c);
      int k = n_res;
      u_tqg_sensor_model.send_pixel(s, f);
      for (int i = 0; i < 40 && n_res == k; i++)
         @(posedge i_clock);
      if (n_res == k)
         give_up();
      #1;
      check(res, {amp(s), 1'b0, d, t, 1'b0, c});
   endtask : pix
   task automatic t_regs();
      check(32'(o_mod_div), 32'h1);
      rdc(`TQG_OFS_CTRL, 32'h1);
      rdc(`TQG_OFS_DIV, 32'h101);
      rdc(`TQG_OFS_THR_WEAK, 32'h19);
      rdc(`TQG_OFS_THR_HIGH, 32'h7d0);
      rdc(`TQG_OFS_TGT_HI, 32'h5dc);
      rdc(8'h3c, 32'h0);
      $display("regs end");
   endtask : t_regs
   task automatic t_grade();
      pix({12'h0, 12'h0, 12'h190, 12'h0}, 1'b1, 1'b0, ACT_DEC, CLS_SATURATED);
      pix({12'h7ee, 36'h0}, 1'b0, 1'b0, ACT_DEC, CLS_TOO_BRIGHT);
      pix({12'h00a, 12'hffb, 12'h014, 12'h0}, 1'b0, 1'b0, ACT_INC, CLS_NO_OBJECT);
      pix({24'h0, 12'h030, 12'h0}, 1'b0, 1'b0, ACT_INC, CLS_WEAK);
      pix({24'h0, 12'h032, 12'h0}, 1'b0, 1'b1, ACT_INC, CLS_NOISY);
      pix({12'h064, 12'hed4, 12'h2bc, 12'h1f4}, 1'b0, 1'b1, ACT_HOLD, CLS_GOOD);
      pix({24'h0, 12'h12c, 12'h0}, 1'b0, 1'b1, ACT_INC, CLS_GOOD);
      pix({12'h830, 12'h0, 12'h7d0, 12'h0}, 1'b0, 1'b1, ACT_DEC, CLS_GOOD);
      pix({12'h82f, 12'h0, 12'h7d1, 12'h0}, 1'b0, 1'b0, ACT_DEC, CLS_OVEREXPOSED);
      wr(`TQG_OFS_THR_WEAK, 32'h32);
      pix({24'h0, 12'h050, 12'h0}, 1'b0, 1'b0, ACT_INC, CLS_WEAK);
      wr(`TQG_OFS_AMR70, 32'h493e0);
      wr(`TQG_OFS_CTRL, 32'h3);
      pix({12'h064, 12'hed4, 12'h2bc, 12'h1f4}, 1'b0, 1'b0, ACT_DEC, CLS_AMBIENT);
      wr(`TQG_OFS_CTRL, 32'h1);
      $display("grading end");
   endtask : t_grade
   task automatic t_irq();
      rdc(`TQG_OFS_STATUS, 32'h7);
      wr(`TQG_OFS_MASK, 32'h2);
      pix({24'h0, 12'h12c, 12'h0}, 1'b0, 1'b1, ACT_INC, CLS_GOOD);
      repeat (2) @(posedge i_clock);
      #1;
      check(32'(o_irq), 32'h1);
      rdc(`TQG_OFS_STATUS, 32'h3);
      #1;
      check(32'(o_irq), 32'h0);
      $display("irq end");
   endtask : t_irq
   task automatic t_div();
      logic [7:0] c [5] = '{8'h0, 8'h1, 8'h3, 8'h7, 8'hf};
      logic [7:0] p, m;
      p = 8'h1;
      wr(`TQG_OFS_DIV, 32'h5);
      rdc(`TQG_OFS_STATUS, 32'h10);
      foreach (c[i])
      begin
         wr(`TQG_OFS_DIV, 32'(c[i]));
         ack_dly <= 4'(i * 3);
         repeat (4) @(posedge i_clock);
         check(32'(o_mod_div), 32'(p));
         u_tqg_sensor_model.frame_end();
         for (int j = 0; j < 60 && o_mod_div !== c[i]; j++)
            @(posedge i_clock);
         if (o_mod_div !== c[i])
            give_up();
         m = c[i] + 8'h1;
         check(32'(mdl_div), 32'(c[i]));
         rdc(`TQG_OFS_INFO, {16'(m * 8'hf), m, m});
         p = c[i];
      end
      rdc(`TQG_OFS_STATUS, 32'h8);
      $display("divider end");
   endtask : t_div
   initial
   begin
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clock);
      t_regs();
      t_grade();
      t_irq();
      t_div();
      results();
   end
endmodule : tqg_grader_tb
